// ==== logic/serial_low_side_switch_ctrl.sv ====
// Notes on behaviour
// - serial data moves in and out only while chip select is low.
// - chip select rising copies the shift register into all eight command latches together.
// - the first serial clock fall of a selection loads drain status of outputs six to zero into the shift register.
// - serial output driven from the first rising serial clock edge of a selection, high impedance while chip select is high.
// - serial input sampled on each falling serial clock edge while selected.
// - serial output moves to the next bit on each rising serial clock edge.
// - serial clock and serial input are ignored while chip select is high.
// - command bit one turns its output off, zero turns it on, at deselection.
// - eight serial clocks in one selection fill the shift register with a command.
// - status bit high for off and healthy, low for on and healthy.
// - words shift first in first out, msb first; first status bit is output seven.
// - serial output ignores the reset input.
// - reset clears the command latches, all outputs off; the shift register is not cleared.
// - protect disable low latches a shorted output off; high keeps it current limiting.
// - after overvoltage the next status word is all ones until reprogrammed.
// - deselection restarts the fault delay; open load is ignored until it expires.
`timescale 1ns/10ps
`default_nettype none

module serial_low_side_switch_ctrl
  import switch_ctrl_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic               si,
  output var  logic               so,
  output var  logic               so_oe,
  input  wire logic               short_protect_disable,
  input  wire logic               overvoltage,
  input  wire logic [OUTPUTS-1:0] overcurrent,
  input  wire logic [OUTPUTS-1:0] overtemp,
  input  wire logic [OUTPUTS-1:0] open_load,
  output var  logic [OUTPUTS-1:0] gate_on,
  output var  logic [OUTPUTS-1:0] current_limit
);

  // ****************************************
  // link domain (serial clock)
  // ****************************************
  logic [OUTPUTS-1:0] shift_reg;
  logic [OUTPUTS-1:0] status_word;
  logic               fresh_rise;
  logic               fresh_fall;

  // cs_n high acts as an asynchronous constant preset, so each frame starts clean
  // even though the serial clock stands still between frames
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh_rise <= 1'b1;
    end else begin
      fresh_rise <= 1'b0;
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh_fall <= 1'b1;
    end else begin
      fresh_fall <= 1'b0;
    end
  end

  // first fall of a frame takes the frozen status word as the parallel load
  always_ff @(negedge sclk) begin
    if (!cs_n) begin
      if (fresh_fall) begin
        shift_reg <= {status_word[MSB-1:0], si};
      end else begin
        shift_reg <= {shift_reg[MSB-1:0], si};
      end
    end
  end

  // no reset input here: the serial output does not care about reset
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so_oe <= 1'b0;
    end else begin
      so_oe <= 1'b1;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so <= 1'b0;
    end else begin
      so <= fresh_rise ? status_word[MSB] : shift_reg[MSB];
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  pin_in_t pins_raw;
  pin_in_t pins_meta;
  pin_in_t pins;

  assign pins_raw = {short_protect_disable, overvoltage, overcurrent, overtemp, open_load, cs_n};

  always_ff @(posedge clock) begin
    pins_meta <= pins_raw;
  end

  // only this second stage is read by the logic below
  always_ff @(posedge clock) begin
    pins <= pins_meta;
  end

  logic cs_prev;
  logic deselect_edge;
  logic idle;

  always_ff @(posedge clock) begin
    if (rst) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= pins.cs_n;
    end
  end

  assign deselect_edge = pins.cs_n & ~cs_prev;
  assign idle          = pins.cs_n & cs_prev;

  // ****************************************
  // command latches
  // ****************************************
  logic               spoilt;

  // the shift register runs on the serial clock, which may stand still, so reset cannot
  // clear it directly; a frame that overlapped reset is latched as all off instead
  always_ff @(posedge clock) begin
    if (rst) begin
      spoilt <= 1'b1;
    end else if (idle) begin
      spoilt <= 1'b0;
    end
  end

  logic [OUTPUTS-1:0] cmd_n;

  // shift_reg is quiet from the last serial fall onward, so it is sampled as a held word
  // two clocks after deselection reaches this domain
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_n <= CMD_ALL_OFF;
    end else if (pins.overvoltage) begin
      cmd_n <= CMD_ALL_OFF;
    end else if (deselect_edge) begin
      cmd_n <= spoilt ? SHIFT_CLEAR : shift_reg;
    end
  end

  logic ov_pending;

  always_ff @(posedge clock) begin
    if (rst) begin
      ov_pending <= 1'b0;
    end else if (pins.overvoltage) begin
      ov_pending <= 1'b1;
    end else if (deselect_edge) begin
      ov_pending <= 1'b0;
    end
  end

  // ****************************************
  // fault delay timer
  // ****************************************
  logic [TIMER_W-1:0] delay_count;
  logic               delay_done;

  always_ff @(posedge clock) begin
    if (rst || deselect_edge) begin
      delay_count <= TIMER_ZERO;
    end else if (!delay_done) begin
      delay_count <= delay_count + TIMER_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || deselect_edge) begin
      delay_done <= 1'b0;
    end else if (!delay_done) begin
      delay_done <= (delay_count == TIMER_LAST);
    end
  end

  // ****************************************
  // per output drive, protection and status
  // ****************************************
  logic [OUTPUTS-1:0] fault_latched;
  logic [OUTPUTS-1:0] driving;
  logic [OUTPUTS-1:0] drain_high;

  for (genvar i = 0; i < OUTPUTS; i++) begin : g_out
    // the set wins over a reprogramming clear in the same cycle
    always_ff @(posedge clock) begin
      if (rst) begin
        fault_latched[i] <= 1'b0;
      end else if (gate_on[i] && pins.overcurrent[i] && !pins.short_protect_disable) begin
        fault_latched[i] <= 1'b1;
      end else if (deselect_edge) begin
        fault_latched[i] <= 1'b0;
      end
    end

    assign driving[i] = ~cmd_n[i] & ~fault_latched[i] & ~pins.overtemp[i] & ~pins.overvoltage;
    // a live short holds the drain high; open load counts only once the delay is over
    assign drain_high[i] = driving[i] ? pins.overcurrent[i]
                                      : ~(pins.open_load[i] & delay_done);

    always_ff @(posedge clock) begin
      if (rst) begin
        gate_on[i] <= 1'b0;
      end else begin
        gate_on[i] <= driving[i];
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        current_limit[i] <= 1'b0;
      end else begin
        current_limit[i] <= driving[i] & pins.overcurrent[i] & pins.short_protect_disable;
      end
    end
  end

  // frozen while selected, so the link reads a steady word
  always_ff @(posedge clock) begin
    if (rst) begin
      status_word <= STATUS_ALL_OFF;
    end else if (idle) begin
      status_word <= ov_pending ? STATUS_ALL_OFF : drain_high;
    end
  end

endmodule

`default_nettype wire

// ==== logic/switch_ctrl_pkg.sv ====
package switch_ctrl_pkg;

  // ****************************************
  // geometry and values
  // ****************************************
  localparam int           OUTPUTS        = 8;
  localparam int           MSB            = OUTPUTS - 1;
  localparam logic [7:0]   CMD_ALL_OFF    = 8'hFF;
  localparam logic [7:0]   STATUS_ALL_OFF = 8'hFF;
  localparam logic [7:0]   SHIFT_CLEAR    = 8'hFF;

  // ****************************************
  // timing
  // ****************************************
  localparam int           CLOCK_PERIOD_NS    = 100;
  localparam int           FAULT_DELAY_NS     = 100000;
  // a least time, so round up to whole cycles
  localparam int           FAULT_DELAY_CYCLES = (FAULT_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int           TIMER_W            = 10;
  localparam logic [TIMER_W-1:0] TIMER_ZERO   = 10'h000;
  localparam logic [TIMER_W-1:0] TIMER_ONE    = 10'h001;
  localparam logic [TIMER_W-1:0] TIMER_LAST   = TIMER_W'(FAULT_DELAY_CYCLES - 1);

  // ****************************************
  // pin bundle that crosses into the system clock
  // ****************************************
  typedef struct packed {
    logic                 short_protect_disable;
    logic                 overvoltage;
    logic [OUTPUTS-1:0]   overcurrent;
    logic [OUTPUTS-1:0]   overtemp;
    logic [OUTPUTS-1:0]   open_load;
    logic                 cs_n;
  } pin_in_t;

endpackage

// ==== sim/host_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_master (
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so
);
  // ****
  // serial bus master, 48 ns bit time
  // ****
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    si   = 1'b0;
    // a real rise of the select clears the edge-triggered serial output flops
    #10 cs_n = 1'b1;
  end
  task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    cs_n <= 1'b0;
    #320;
    for (int i = n - 1; i >= 0; i--) begin
      #5 si = w[i];
      #19 sclk = 1'b1;
      #24 sclk = 1'b0;
      r = {r[14:0], so};
    end
    #24 cs_n = 1'b1;
    #5 si = ~si;
  endtask
  // deliberate clocking while deselected, which the device must ignore
  task automatic noise();
    repeat (4) begin
      #24 sclk = 1'b1;
      si = ~si;
      #24 sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/switch_ctrl_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module switch_ctrl_chk
  import switch_ctrl_pkg::*;
(
  input wire logic               clock,
  input wire logic               rst,
  input wire logic               cs_n,
  input wire logic               so,
  input wire logic               so_oe,
  input wire logic               short_protect_disable,
  input wire logic               overvoltage,
  input wire logic [OUTPUTS-1:0] overcurrent,
  input wire logic [OUTPUTS-1:0] gate_on,
  input wire logic [OUTPUTS-1:0] current_limit
);
  // ****
  // checks on the system clock
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [2:0] low_cnt;
  logic       calm;
  assign calm = !overvoltage && overcurrent == 8'h00;
  // cs_n is asynchronous, so only trust it after seven cycles
  always_ff @(posedge clock) begin
    if (rst || cs_n) low_cnt <= 3'h0;
    else if (low_cnt != 3'h7) low_cnt <= low_cnt + 3'h1;
  end
  property p_oe_off; cs_n && $past(cs_n) |-> !so_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("so enabled");
  property p_so_low; cs_n && $past(cs_n) |-> !so; endproperty
  a_so_low: assert property (p_so_low) else $error("so moved");
  property p_reset; disable iff (1'b0) rst |=> gate_on == 8'h00 && current_limit == 8'h00; endproperty
  a_reset: assert property (p_reset) else $error("reset");
  property p_hold; low_cnt == 3'h7 && calm |=> $stable(gate_on); endproperty
  a_hold: assert property (p_hold) else $error("gate moved");
  property p_delay; $rose(cs_n) && calm |-> $stable(gate_on)[*3]; endproperty
  a_delay: assert property (p_delay) else $error("early latch");
  property p_ovolt; overvoltage[*5] |-> gate_on == 8'h00; endproperty
  a_ovolt: assert property (p_ovolt) else $error("ov on");
  property p_limit; (current_limit & ~gate_on) == 8'h00; endproperty
  a_limit: assert property (p_limit) else $error("limit off");
  property p_latch; (!short_protect_disable)[*4] |-> current_limit == 8'h00; endproperty
  a_latch: assert property (p_latch) else $error("limit mode");
  c_limit: cover property (current_limit != 8'h00);
  c_ovolt: cover property (overvoltage && gate_on == 8'h00);
  c_frame: cover property (low_cnt == 3'h7);
endmodule
bind serial_low_side_switch_ctrl switch_ctrl_chk i_chk (.clock(clock), .rst(rst), .cs_n(cs_n), .so(so),
  .so_oe(so_oe), .short_protect_disable(short_protect_disable), .overvoltage(overvoltage),
  .overcurrent(overcurrent), .gate_on(gate_on), .current_limit(current_limit));
`default_nettype wire

// ==== sim/test_serial_low_side_switch_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_serial_low_side_switch_ctrl
  import switch_ctrl_pkg::*;
;
  // ****
  // bench
  // ****
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        short_protect_disable = 1'b0;
  logic        overvoltage = 1'b0;
  logic [7:0]  overcurrent = 8'h00;
  logic [7:0]  quiet = 8'h00;
  logic [7:0]  open_load = 8'h00;
  logic        sclk, cs_n, si, so, so_oe;
  logic [7:0]  gate_on, current_limit;
  logic [15:0] st;
  int          n_mismatch = 0;
  int          n_checks = 0;
  always #50 clock = ~clock;
  host_master i_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
  serial_low_side_switch_ctrl i_dut (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .short_protect_disable(short_protect_disable), .overvoltage(overvoltage),
    .overcurrent(overcurrent), .overtemp(quiet), .open_load(open_load), .gate_on(gate_on),
    .current_limit(current_limit));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // the gap covers the latch delay and the minimum deselect time
  task automatic frame(input int n, input logic [15:0] w);
    i_host.xfer(n, w, st);
    repeat (10) @(posedge clock);
  endtask
  initial begin
    #1_000_000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clock);
    check(gate_on, 8'h00);
    rst <= 1'b0;
    @(posedge clock);
    frame(8, 16'h00A5);
    check(st[7:0], 8'hFF);
    check(gate_on, 8'h5A);
    // open load on an output that stays off; masked until the fault delay has run out
    open_load <= 8'h20;
    i_host.noise();
    repeat (5) @(posedge clock);
    check(gate_on, 8'h5A);
    frame(8, 16'h003C);
    check(st[7:0], 8'hA5);
    check(gate_on, 8'hC3);
    repeat (1010) @(posedge clock);
    frame(16, 16'h0FF0);
    check(st[15:8], 8'h1C);
    check(st[7:0], 8'h0F);
    check(gate_on, 8'h0F);
    overvoltage <= 1'b1;
    repeat (10) @(posedge clock);
    check(gate_on, 8'h00);
    overvoltage <= 1'b0;
    repeat (5) @(posedge clock);
    frame(8, 16'h0000);
    check(st[7:0], 8'hFF);
    check(gate_on, 8'hFF);
    short_protect_disable <= 1'b1;
    overcurrent <= 8'h01;
    repeat (6) @(posedge clock);
    check(current_limit, 8'h01);
    short_protect_disable <= 1'b0;
    repeat (6) @(posedge clock);
    check(gate_on, 8'hFE);
    overcurrent <= 8'h00;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    check(gate_on, 8'h00);
    // reset is released in mid-frame, before the first serial clock: the word of that frame must not reach the outputs
    fork
      frame(8, 16'h0000);
      begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
      end
    join
    check(st[7:0], 8'hFF);
    check(gate_on, 8'h00);
    repeat (2) @(posedge clock);
    finish_test();
  end
endmodule
`default_nettype wire
